// File: src/sss_pkg.sv
// Notes on behaviour
// RULE1: Mode input low is slave, high streams.
// RULE2: Slave samples SDI rising, changes SDO falling.
// RULE3: First bit: 1 read, 0 write.
// RULE4: 15-bit address, low 10 decoded, 16-bit data.
// RULE5: One chip-select-low period, one register.
// RULE6: Write commits at CS rise, exactly 32 clocks.
// RULE7: Read fetches data after 16 clocks, updates echo.
// RULE8: Read-to-clear only after echo updated.
// RULE9: Register accesses rejected while streaming.
// RULE10: Mode rise starts stream; fall finishes sample.
// RULE11: Stream clock is sysclk over (2*div+2).
// RULE12: Pin-swap bit 8 exchanges data pin direction.
// RULE13: Stream only channels enabled in bits 15:9.
// RULE14: Bits 4,5 pick drive edge, idle level.
// RULE15: No sample: CS high two periods, clock idle.
// RULE16: Order I4,I1,V1,I2,V2,I3,V3, skip disabled.
// RULE17: Width from bits 7:6, MSB first.
// RULE18: Configure, match settings, raise mode; 125us.
// RULE19: After lowering mode wait one sample period.
// RULE20: CS high abandons transaction, clears counter.
package sss_pkg;
  localparam int unsigned CLK_NS    = 5;            // System clock period
  localparam int unsigned SAMPLE_NS = 125000;       // One 8 kHz period
  localparam int unsigned STOP_WAIT_CYC = SAMPLE_NS / CLK_NS;
  localparam int unsigned NCH_DEF   = 7;            // Sample channels
  localparam int unsigned HOST_HALF = 8;            // Host half period
  localparam logic [9:0]  ADDR_CTRL = 10'h00e;      // stream_control
  localparam logic [9:0]  ADDR_ECHO = 10'h00f;      // last_transfer_echo
  localparam logic [15:0] CTRL_RST  = 16'h0000;     // Control reset
  localparam int unsigned DIV_LSB   = 0;            // Divider field
  localparam int unsigned DRV_BIT   = 4;            // first_edge_drive
  localparam int unsigned IDLE_BIT  = 5;            // Clock idle level
  localparam int unsigned WID_LSB   = 6;            // sample_width_select
  localparam int unsigned SWAP_BIT  = 8;            // Pin swap
  localparam int unsigned CHEN_LSB  = 9;            // channel_dump_enable
  localparam logic [5:0]  CNT_HDR   = 6'h0f;        // Count before 16th
  localparam logic [5:0]  CNT_FULL  = 6'h20;        // 32 clocks
  localparam logic [5:0]  CNT_MAX   = 6'h3f;        // Counter saturation
  localparam logic [5:0]  NB_16     = 6'h0f;        // Bits minus one
  localparam logic [5:0]  NB_24     = 6'h17;
  localparam logic [5:0]  NB_32     = 6'h1f;
  localparam logic [1:0]  WID_16    = 2'h0;
  localparam logic [1:0]  WID_24    = 2'h1;
  localparam int unsigned GAP_PER   = 2;            // CS-high periods
  localparam logic [2:0]  H_CMD     = 3'h0;         // Host registers
  localparam logic [2:0]  H_WDATA   = 3'h1;
  localparam logic [2:0]  H_STAT    = 3'h2;
  localparam logic [2:0]  H_RDATA   = 3'h3;
  localparam logic [2:0]  H_SCFG    = 3'h4;
  localparam logic [2:0]  H_MODE    = 3'h5;
  localparam logic [2:0]  H_RXHI    = 3'h6;
  localparam logic [2:0]  H_RXLO    = 3'h7;
  typedef enum logic [2:0] {
    M_IDLE = 3'b001, M_XFER = 3'b010, M_GAP = 3'b100
  } sss_mst_e;
endpackage

// File: src/sss_if.sv
`timescale 1ns/1ps
interface sss_if;
  logic dev_cs_o, dev_cs_oe, dev_sk_o, dev_sk_oe;     // Device drives
  logic dev_di_o, dev_di_oe, dev_do_o, dev_do_oe;
  logic host_cs_o, host_cs_oe, host_sk_o, host_sk_oe; // Host drives
  logic host_di_o, host_di_oe, host_do_o, host_do_oe;
  logic mode_sel;                                     // From host only
  logic cs, sclk, sdi, sdo;                           // Wire levels
  // Resolved pins, pulled high when nobody drives
  assign cs   = dev_cs_oe ? dev_cs_o : host_cs_oe ? host_cs_o : 1'b1;
  assign sclk = dev_sk_oe ? dev_sk_o : host_sk_oe ? host_sk_o : 1'b1;
  assign sdi  = dev_di_oe ? dev_di_o : host_di_oe ? host_di_o : 1'b1;
  assign sdo  = dev_do_oe ? dev_do_o : host_do_oe ? host_do_o : 1'b1;
  modport dev (output dev_cs_o, dev_cs_oe, dev_sk_o, dev_sk_oe,
               output dev_di_o, dev_di_oe, dev_do_o, dev_do_oe,
               input cs, sclk, sdi, sdo, mode_sel);
  modport host (output host_cs_o, host_cs_oe, host_sk_o, host_sk_oe,
                output host_di_o, host_di_oe, host_do_o, host_do_oe,
                output mode_sel, input cs, sclk, sdi, sdo);
endinterface

// File: src/sss_sync.sv
`timescale 1ns/1ps
module sss_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] m_q;  // First stage, read by q only
  // Two-stage synchroniser
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      m_q <= '0;
      q   <= '0;
    end else begin
      m_q <= d;
      q   <= m_q;
    end
  end
endmodule

// File: src/sss_dev.sv
`timescale 1ns/1ps
module sss_dev import sss_pkg::*; #(
  parameter int NCH = NCH_DEF
) (
  input  wire logic              clock,
  input  wire logic              rst,
  sss_if.dev                     pins,
  output logic [9:0]             acc_addr,
  output logic                   acc_rd,
  input  wire logic [15:0]       acc_rdata,
  output logic                   acc_rclr,
  output logic                   acc_wr,
  output logic [15:0]            acc_wdata,
  input  wire logic              samp_stb,
  input  wire logic [NCH*32-1:0] samp_data,
  output logic                   streaming
);
  logic [3:0] s;                       // Synced cs, sclk, sdi, mode
  logic       sk_p_q, cs_p_q;          // Previous synced levels
  logic [5:0] cnt_q;                   // Slave clock count
  logic [31:0] sh_q;                   // Slave input shift
  logic       at16_q, rreq_q, rdv_q, rd_act_q; // Read fetch stages
  logic [15:0] rd_q, echo_q, ctrl_q;   // Read data, echo, control
  logic       master_q;                // Streaming active
  sss_mst_e   st_q, st_d;              // Master state
  logic [3:0] hc_q, hc_d;              // Half-period counter
  logic       h_q, h_d;                // Second half of bit
  logic [5:0] nb_q, nb_d;              // Bits left minus one
  logic [31:0] tx_q, tx_d;             // Master output shift
  logic [NCH-1:0] pend_q, pend_d;      // Channels still to send
  logic [7:0] gc_q, gc_d;              // Gap counter
  logic [31:0] smp_q [NCH];            // Captured sample set
  logic cs_o_q, cs_oe_q, sk_o_q, sk_oe_q;
  logic di_o_q, di_oe_q, do_o_q, do_oe_q;

  sss_sync #(.W(4)) u_sync (
    .clock (clock),
    .rst   (rst),
    // Select enters inverted so the cleared stages read as deselected
    .d     ({~pins.cs, pins.sclk, pins.sdi, pins.mode_sel}),
    .q     (s)
  );

  // Decoding of synced pins and fields
  wire cs_s    = ~s[3];                            // High after reset
  wire sk_s    = s[2];
  wire sdi_s   = s[1];
  wire mode_s  = s[0];
  wire sk_rise = sk_s & ~sk_p_q;
  wire sk_fall = ~sk_s & sk_p_q;
  wire cs_rise = cs_s & ~cs_p_q;
  wire sel     = ~master_q & ~cs_s;                // [RULE9] [RULE20]
  wire [9:0] sa  = sh_q[9:0];                      // [RULE4]
  wire [9:0] wa  = sh_q[25:16];                    // [RULE4]
  wire rloc    = (sa == ADDR_CTRL) | (sa == ADDR_ECHO);
  wire wcm     = ~master_q & cs_rise & (cnt_q == CNT_FULL)
               & ~sh_q[31];                        // [RULE3] [RULE6]
  wire [15:0] rdat = (sa == ADDR_CTRL) ? ctrl_q :
                     (sa == ADDR_ECHO) ? echo_q : acc_rdata;
  wire [3:0] div   = ctrl_q[DIV_LSB +: 4];
  wire       drv   = ctrl_q[DRV_BIT];
  wire       idle  = ctrl_q[IDLE_BIT];
  wire       swap  = ctrl_q[SWAP_BIT];
  wire [1:0] wsel  = ctrl_q[WID_LSB +: 2];
  wire [NCH-1:0] chen = ctrl_q[CHEN_LSB +: NCH];
  wire [5:0] nbits = (wsel == WID_16) ? NB_16 :
                     (wsel == WID_24) ? NB_24 : NB_32;  // [RULE17]
  wire [7:0] gap   = 8'(GAP_PER * (2 * div + 2));       // [RULE15]
  wire       load  = samp_stb & master_q & mode_s & (pend_q == '0);

  // Lowest pending index, which is the earliest in the send order
  function automatic logic [2:0] first_set(input logic [NCH-1:0] m);
    first_set = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (m[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction

  wire [2:0] fch = first_set(pend_q);             // [RULE16]

  // Edge history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sk_p_q <= 1'b0;
      cs_p_q <= 1'b1;
    end else begin
      sk_p_q <= sk_s;
      cs_p_q <= cs_s;
    end
  end

  // Slave bit counter and input shift
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      sh_q  <= '0;
    end else begin
      if (!sel) begin
        cnt_q <= '0;                               // [RULE20] [RULE5]
      end else if (sk_rise && cnt_q != CNT_MAX) begin
        cnt_q <= cnt_q + 6'h01;
      end
      if (sel && sk_rise) begin
        sh_q <= {sh_q[30:0], sdi_s};               // [RULE2]
      end
    end
  end

  // Read fetch: 16th clock, request, data, then clear release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      at16_q   <= 1'b0;
      rreq_q   <= 1'b0;
      rdv_q    <= 1'b0;
      rd_act_q <= 1'b0;
      acc_rd   <= 1'b0;
      acc_rclr <= 1'b0;
      rd_q     <= '0;
    end else begin
      at16_q   <= sel & sk_rise & (cnt_q == CNT_HDR);     // [RULE7]
      rreq_q   <= at16_q & sh_q[15];                      // [RULE3]
      // Outside read data only stands the cycle after the request
      rdv_q    <= rreq_q;
      acc_rd   <= at16_q & sh_q[15] & ~rloc;              // [RULE7]
      acc_rclr <= rdv_q & ~rloc;                          // [RULE8]
      if (!sel) begin
        rd_act_q <= 1'b0;
      end else if (at16_q) begin
        rd_act_q <= sh_q[15];
      end
      if (rdv_q) begin
        rd_q <= rdat;                                     // [RULE7]
      end
    end
  end

  // Echo, control register and write port
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      echo_q    <= '0;
      ctrl_q    <= CTRL_RST;
      acc_wr    <= 1'b0;
      acc_wdata <= '0;
      acc_addr  <= '0;
    end else begin
      acc_wr <= wcm & (wa != ADDR_CTRL) & (wa != ADDR_ECHO); // [RULE6]
      if (wcm) begin
        echo_q    <= sh_q[15:0];
        acc_wdata <= sh_q[15:0];
        acc_addr  <= wa;
      end else if (rdv_q) begin
        echo_q <= rdat;                                   // [RULE7]
      end else if (at16_q) begin
        acc_addr <= sa;
      end
      if (wcm && wa == ADDR_CTRL) begin
        ctrl_q <= sh_q[15:0];                             // [RULE6]
      end
    end
  end

  // Master sequencing next state
  always_comb begin
    st_d   = st_q;
    hc_d   = hc_q;
    h_d    = h_q;
    nb_d   = nb_q;
    tx_d   = tx_q;
    pend_d = pend_q;
    gc_d   = gc_q;
    case (st_q)
      M_IDLE: begin
        if (pend_q != '0) begin                   // [RULE15]
          st_d      = M_XFER;
          tx_d      = smp_q[fch];                 // [RULE16]
          pend_d[fch] = 1'b0;
          nb_d      = nbits;
          hc_d      = '0;
          h_d       = 1'b0;
        end
      end
      M_XFER: begin
        if (hc_q == div) begin                    // [RULE11]
          hc_d = '0;
          h_d  = ~h_q;
          if (h_q) begin
            if (nb_q == '0) begin
              st_d = M_GAP;
              gc_d = gap;                         // [RULE15]
            end else begin
              nb_d = nb_q - 6'h01;
              tx_d = {tx_q[30:0], 1'b0};          // [RULE17]
            end
          end
        end else begin
          hc_d = hc_q + 4'h1;
        end
      end
      M_GAP: begin
        if (gc_q == '0) begin
          st_d = M_IDLE;
        end else begin
          gc_d = gc_q - 8'h01;
        end
      end
      default: st_d = M_IDLE;
    endcase
    if (load) begin
      pend_d = chen;                              // [RULE13]
    end
  end

  // Master registers and mode tracking
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      master_q <= 1'b0;
      st_q     <= M_IDLE;
      hc_q     <= '0;
      h_q      <= 1'b0;
      nb_q     <= '0;
      tx_q     <= '0;
      pend_q   <= '0;
      gc_q     <= '0;
    end else begin
      if (!master_q && mode_s && cs_s) begin
        master_q <= 1'b1;                         // [RULE1] [RULE10]
      end else if (master_q && !mode_s && st_q == M_IDLE
                   && pend_q == '0) begin
        master_q <= 1'b0;                         // [RULE10]
      end
      st_q   <= st_d;
      hc_q   <= hc_d;
      h_q    <= h_d;
      nb_q   <= nb_d;
      tx_q   <= tx_d;
      pend_q <= pend_d;
      gc_q   <= gc_d;
    end
  end

  // Per-channel sample capture
  for (genvar k = 0; k < NCH; k++) begin : g_smp
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        smp_q[k] <= '0;
      end else if (load) begin
        smp_q[k] <= samp_data[k*32 +: 32];
      end
    end
  end

  // Pin drivers for both modes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cs_o_q  <= 1'b1;
      cs_oe_q <= 1'b0;
      sk_o_q  <= 1'b0;
      sk_oe_q <= 1'b0;
      di_o_q  <= 1'b0;
      di_oe_q <= 1'b0;
      do_o_q  <= 1'b0;
      do_oe_q <= 1'b0;
    end else if (master_q) begin
      cs_o_q  <= st_d != M_XFER;
      cs_oe_q <= 1'b1;
      sk_o_q  <= (st_d == M_XFER) ? idle ^ (drv ? ~h_d : h_d)
                                   : idle;          // [RULE14] [RULE15]
      sk_oe_q <= 1'b1;
      di_o_q  <= tx_d[31];                          // [RULE17]
      do_o_q  <= tx_d[31];
      di_oe_q <= swap;                              // [RULE12]
      do_oe_q <= ~swap;                             // [RULE12]
    end else begin
      cs_o_q  <= 1'b1;
      cs_oe_q <= 1'b0;
      sk_oe_q <= 1'b0;
      di_oe_q <= 1'b0;
      do_oe_q <= sel;
      if (sel && sk_fall && rd_act_q && cnt_q[4] && !cnt_q[5]) begin
        do_o_q <= rd_q[~cnt_q[3:0]];                // [RULE2] [RULE7]
      end
    end
  end

  assign streaming      = master_q;
  assign pins.dev_cs_o  = cs_o_q;
  assign pins.dev_cs_oe = cs_oe_q;
  assign pins.dev_sk_o  = sk_o_q;
  assign pins.dev_sk_oe = sk_oe_q;
  assign pins.dev_di_o  = di_o_q;
  assign pins.dev_di_oe = di_oe_q;
  assign pins.dev_do_o  = do_o_q;
  assign pins.dev_do_oe = do_oe_q;
endmodule

// File: src/sss_host.sv
`timescale 1ns/1ps
module sss_host import sss_pkg::*; #(
  parameter int unsigned HALF      = HOST_HALF,
  parameter int unsigned STOP_WAIT = STOP_WAIT_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst,
  sss_if.host              pins,
  input  wire logic [2:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [15:0] sw_rdata
);
  localparam int WW = $clog2(STOP_WAIT + 1);
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001, HS_XFER = 3'b010, HS_GAP = 3'b100
  } sss_hst_e;
  logic [3:0]  s;                      // Synced cs, sclk, sdo, sdi
  logic        sk_p_q, cs_p_q;         // Previous levels
  sss_hst_e    st_q;                   // Transaction state
  logic [7:0]  hc_q;                   // Half-period counter
  logic        ph_q;                   // Clock high half
  logic [5:0]  bc_q;                   // Bit index
  logic [31:0] tx_q, rsh_q, rx_q;      // Shifts and last sample
  logic [15:0] wd_q, rdat_q, scfg_q;   // Write data, read data, config
  logic        mode_q, rdy_q;          // Mode output, sample ready
  logic [WW-1:0] wait_q;               // Stop settle counter
  logic cs_q, sk_q, di_q, oe_q;        // Pin drivers

  sss_sync #(.W(4)) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({pins.cs, pins.sclk, pins.sdo, pins.sdi}),
    .q     (s)
  );

  // Decoding
  wire idle  = scfg_q[IDLE_BIT];
  wire drv   = scfg_q[DRV_BIT];
  wire dat   = scfg_q[SWAP_BIT] ? s[0] : s[1];
  wire chg   = s[2] ^ sk_p_q;
  wire lead  = chg & (s[2] != idle);
  wire smp   = drv ? (chg & ~lead) : lead;          // [RULE14]
  wire busy  = st_q != HS_IDLE;
  wire rxon  = mode_q | (wait_q != '0);             // Stream may still run
  wire go    = sw_wr & (sw_addr == H_CMD) & ~busy & ~mode_q
             & (wait_q == '0);                      // [RULE9] [RULE19]
  wire hend  = hc_q == 8'(HALF - 1);
  wire rxclr = sw_rd & (sw_addr == H_RXLO);
  wire rxset = rxon & s[3] & ~cs_p_q;               // [RULE5] [RULE10]
  wire [15:0] rmux =
    (sw_addr == H_WDATA) ? wd_q :
    (sw_addr == H_STAT)  ? {13'h0000, rdy_q, wait_q != '0, busy} :
    (sw_addr == H_RDATA) ? rdat_q :
    (sw_addr == H_SCFG)  ? scfg_q :
    (sw_addr == H_MODE)  ? {15'h0000, mode_q} :
    (sw_addr == H_RXHI)  ? rx_q[31:16] :
    (sw_addr == H_RXLO)  ? rx_q[15:0] : 16'h0000;

  // Software registers, mode and settle wait
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wd_q     <= '0;
      scfg_q   <= CTRL_RST;
      mode_q   <= 1'b0;
      wait_q   <= '0;
      sw_rdata <= '0;
      rdy_q    <= 1'b0;
      rx_q     <= '0;
    end else begin
      sw_rdata <= sw_rd ? rmux : 16'h0000;
      if (sw_wr && sw_addr == H_WDATA) wd_q <= sw_wdata;
      if (sw_wr && sw_addr == H_SCFG) scfg_q <= sw_wdata;
      if (sw_wr && sw_addr == H_MODE && !busy) begin
        mode_q <= sw_wdata[0];                      // [RULE1] [RULE18]
        if (mode_q && !sw_wdata[0]) begin
          wait_q <= WW'(STOP_WAIT);                 // [RULE19]
        end
      end else if (wait_q != '0) begin
        wait_q <= wait_q - 1'b1;
      end
      if (rxset) rx_q <= rsh_q;
      rdy_q <= rxset | (rdy_q & ~rxclr);
    end
  end

  // Register transaction and stream receive
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q   <= HS_IDLE;
      hc_q   <= '0;
      ph_q   <= 1'b0;
      bc_q   <= '0;
      tx_q   <= '0;
      rsh_q  <= '0;
      rdat_q <= '0;
    end else begin
      case (st_q)
        HS_IDLE: begin
          if (go) begin
            st_q <= HS_XFER;
            tx_q <= {sw_wdata, wd_q};               // [RULE3] [RULE4]
            hc_q <= '0;
            ph_q <= 1'b0;
            bc_q <= '0;
          end else if (rxon && !s[3] && smp) begin
            rsh_q <= {rsh_q[30:0], dat};            // [RULE17]
          end
        end
        HS_XFER: begin
          hc_q <= hend ? 8'h00 : hc_q + 8'h01;
          if (hend) begin
            ph_q <= ~ph_q;
            if (ph_q) begin
              rsh_q <= {rsh_q[30:0], s[1]};
              tx_q  <= {tx_q[30:0], 1'b0};
              bc_q  <= bc_q + 6'h01;
              if (bc_q == CNT_FULL - 6'h01) begin
                st_q   <= HS_GAP;                   // [RULE5]
                rdat_q <= {rsh_q[14:0], s[1]};
              end
            end
          end
        end
        HS_GAP: begin
          hc_q <= hend ? 8'h00 : hc_q + 8'h01;
          if (hend) st_q <= HS_IDLE;
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  // Pin drivers, one cycle behind the state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sk_p_q <= 1'b0;
      cs_p_q <= 1'b1;
      cs_q   <= 1'b1;
      sk_q   <= 1'b0;
      di_q   <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      sk_p_q <= s[2];
      cs_p_q <= s[3];
      cs_q   <= st_q != HS_XFER;
      sk_q   <= (st_q == HS_XFER) & ph_q;
      di_q   <= tx_q[31];
      oe_q   <= ~mode_q & (wait_q == '0);           // [RULE19]
    end
  end

  assign pins.mode_sel   = mode_q;
  assign pins.host_cs_o  = cs_q;
  assign pins.host_cs_oe = oe_q;
  assign pins.host_sk_o  = sk_q;
  assign pins.host_sk_oe = oe_q;
  assign pins.host_di_o  = di_q;
  assign pins.host_di_oe = oe_q;
  assign pins.host_do_o  = 1'b0;
  assign pins.host_do_oe = 1'b0;
endmodule

// File: tb/sss_checker.sv
`timescale 1ns/1ps
// Pin-level watch on the link between the two ends
module sss_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic cs,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic mode_sel,
  input wire logic dev_cs_oe,
  input wire logic dev_sk_oe,
  input wire logic dev_do_oe,
  input wire logic host_cs_oe,
  input wire logic host_sk_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_one_clock_owner: assert property (
    dev_sk_oe |-> !host_sk_oe) else $error("clock driven by both ends");
  chk_one_select_owner: assert property (
    dev_cs_oe |-> !host_cs_oe && dev_sk_oe)
    else $error("select owner clash");
  chk_sdo_still_high: assert property (
    !dev_cs_oe && dev_do_oe && $past(dev_do_oe) && sclk && $past(sclk)
    |-> $stable(sdo)) else $error("sdo moved while clock high");
  chk_gap_clock_idle: assert property (
    dev_cs_oe && $past(dev_cs_oe) && dev_sk_oe && $past(dev_sk_oe)
    && cs && $past(cs) |-> $stable(sclk)) else $error("clock moved in gap");
  chk_gap_min_len: assert property (
    $rose(cs) && dev_cs_oe |-> cs [*4]) else $error("select gap too short");
  chk_stream_needs_mode: assert property (
    $rose(dev_cs_oe) |-> $past(mode_sel))
    else $error("stream began without mode");
  chk_sample_finishes: assert property (
    $fell(mode_sel) && dev_cs_oe && !cs |-> dev_cs_oe [*8])
    else $error("sample cut short");
  chk_sdo_released: assert property (
    $rose(cs) && !dev_cs_oe |-> ##[0:6] !dev_do_oe)
    else $error("sdo held after deselect");
endmodule

// File: tb/spi_slave_dma_sample_streamer_bench.sv
`timescale 1ns/1ps
// Both ends joined by pins; bench drives host software side and device
module spi_slave_dma_sample_streamer_bench import sss_pkg::*;;
  logic                  clock, rst, sw_wr, sw_rd, samp_stb;
  logic [2:0]            sw_addr;
  logic [15:0]           sw_wdata, sw_rdata, acc_rdata, acc_wdata;
  logic [15:0]           last_rd, ctrl, ud;
  logic [9:0]            acc_addr, ua;
  logic                  acc_rd, acc_rclr, acc_wr, streaming;
  logic                  rd_d, rd1, rd2, sk_p, run_lo;
  logic [NCH_DEF*32-1:0] samp_data;
  logic [15:0]           mem [1024];    // User register file
  logic [16:0]           exp_q [$];     // Bit 16 set: compare the read
  logic [25:0]           wr_q [$];      // Expected address and data
  logic [16:0]           note;
  int                    miscompares, checks, per, cnt, lo;
  sss_if bus ();
  wire rise = bus.sclk && !sk_p;        // Link clock rising
  sss_dev sss_dev_inst (.clock, .rst, .pins(bus.dev), .acc_addr,
    .acc_rd, .acc_rdata, .acc_rclr, .acc_wr, .acc_wdata, .samp_stb,
    .samp_data, .streaming);
  sss_host #(.HALF(8), .STOP_WAIT(1500)) sss_host_inst (.clock, .rst,
    .pins(bus.host), .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata);
  sss_checker sss_checker_inst (.clock, .rst, .cs(bus.cs),
    .sclk(bus.sclk), .sdo(bus.sdo), .mode_sel(bus.mode_sel),
    .dev_cs_oe(bus.dev_cs_oe), .dev_sk_oe(bus.dev_sk_oe),
    .dev_do_oe(bus.dev_do_oe), .host_cs_oe(bus.host_cs_oe),
    .host_sk_oe(bus.host_sk_oe));
  // Clock at 200 MHz
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen,
               want);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1;
    @(posedge clock);
    sw_wr <= 0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [16:0] n);
    @(posedge clock);
    sw_addr <= a;
    sw_rd <= 1;
    exp_q.push_back(n);
    @(posedge clock);
    sw_rd <= 0;
  endtask
  task automatic poll(input logic [2:0] a, output logic [15:0] v);
    rd(a, 17'h0);
    @(posedge clock);
    #1 v = last_rd;
  endtask
  task automatic waits(input logic [15:0] msk, input logic [15:0] want);
    logic [15:0] s;
    poll(H_STAT, s);
    for (int i = 0; i < 9000 && (s & msk) !== want; i++) poll(H_STAT, s);
    chk(s & msk, want);
  endtask
  task automatic spi(input logic rw, input logic [9:0] a,
                     input logic [15:0] d);
    wr(H_WDATA, d);
    wr(H_CMD, {rw, 5'($urandom), a});
    waits(16'h1, 16'h0);
  endtask
  // Read results: oldest note against the data in the following cycle
  always @(posedge clock) begin
    if (rd_d) begin
      last_rd = sw_rdata;
      note = exp_q.pop_front();
      if (note[16]) chk(sw_rdata, note[15:0]);
    end
    rd_d <= sw_rd;
  end
  // User register file behind the device access port
  always @(posedge clock) begin
    if (acc_rd) acc_rdata <= mem[acc_addr];
    if (acc_wr) begin
      mem[acc_addr] <= acc_wdata;
      chk({acc_addr, acc_wdata}, wr_q.pop_front());
    end
    if (acc_rclr || rd2) chk(acc_rclr, rd2);
    rd1 <= acc_rd;
    rd2 <= rd1;
  end
  // Link clock period between rises inside one select-low frame
  always @(posedge clock) begin
    sk_p <= bus.sclk;
    cnt <= rise ? 1 : cnt + 1;
    if (rise && run_lo) per <= cnt;
    run_lo <= bus.cs ? 1'b0 : (rise ? 1'b1 : run_lo);
  end
  // Hang guard
  initial begin
    repeat (90000) @(posedge clock);
    miscompares++;
    wrap_up();
  end
  initial begin
    {rst, sw_wr, sw_rd, sw_addr, sw_wdata, samp_stb} = 23'h400000;
    {samp_data, acc_rdata, rd_d, cnt} = '0;
    void'($urandom(32'he31f));
    repeat (2) @(posedge clock);
    rst <= 0;
    rd(H_STAT, 17'h10000);
    ua = 10'($urandom_range(16, 1023));
    ud = 16'($urandom);
    wr_q.push_back({ua, ud});
    spi(1'b0, ua, ud);
    spi(1'b1, ua, 16'h0);
    rd(H_RDATA, {1'b1, ud});
    spi(1'b1, ADDR_ECHO, 16'h0);
    rd(H_RDATA, {1'b1, ud});
    $display("test slave access done");
    for (int m = 0; m < 4; m++) begin
      // Every clock mode, pin swap when m is 1 or 2, random divider
      ctrl = {7'h29, 1'(m[0] ^ m[1]), 2'(m), 2'(m),
              4'($urandom_range(0, 3))};
      spi(1'b0, ADDR_CTRL, ctrl);
      spi(1'b1, ADDR_CTRL, 16'h0);
      rd(H_RDATA, {1'b1, ctrl});
      wr(H_SCFG, ctrl & 16'h0130);
      wr(H_MODE, 16'h1);
      for (int k = 0; k < NCH_DEF; k++) samp_data[32*k +: 32] <= $urandom;
      for (int i = 0; i < 20 && !streaming; i++) @(posedge clock);
      samp_stb <= 1;
      @(posedge clock);
      samp_stb <= 0;
      for (int k = 0; k < NCH_DEF; k++) begin
        if (ctrl[9+k]) begin
          waits(16'h4, 16'h4);
          // Narrow samples land in the low bits of the receive word
          lo = 32 * k + 16 - 8 * (m > 1 ? 2 : m);
          rd(H_RXHI, {m > 1, samp_data[32*k+16 +: 16]});
          rd(H_RXLO, {1'b1, samp_data[lo +: 16]});
          chk(per, 2 * ctrl[3:0] + 2);
          if (k == 0) wr(H_MODE, 16'h0);
        end
      end
      for (int i = 0; i < 2000 && streaming; i++) @(posedge clock);
      chk(streaming, 1'b0);
      waits(16'h3, 16'h0);
      $display("test stream mode %0d done", m);
    end
    wrap_up();
  end
endmodule
